// File: cfg_reset_map.vh
// register offsets, field positions and reset values of the reset option decoder
`ifndef CFG_RESET_MAP_VH
`define CFG_RESET_MAP_VH
`define ADR_CFG_WORD 4'h0
`define ADR_BOR_CTRL 4'h1
`define ADR_CAUSE 4'h2
`define ADR_STATUS 4'h3
`define ADR_WDT_CTRL 4'h4
`define ADR_OPT_STAT 4'h5
`define CFG_CP_BIT 7
`define CFG_RPFS_BIT 6
`define CFG_PUTE_BIT 5
`define CFG_WATCHDOG_ENABLE_FIELD_HI 4
`define CFG_WATCHDOG_ENABLE_FIELD_LO 3
`define CFG_BORE_HI 10
`define CFG_BORE_LO 9
`define BORC_SWEN_BIT 7
`define BORC_FAST_BIT 6
`define BORC_RDY_BIT 0
`define WDTC_SWEN_BIT 0
`define WDTC_PS_HI 5
`define WDTC_PS_LO 1
`define MODE_OFF 2'h0
`define MODE_SW 2'h1
`define MODE_RUN 2'h2
`define MODE_ON 2'h3
`define BORC_WMASK 8'hc0
`define CAUSE_WMASK 8'hdf
`define STATUS_RMASK 8'h1f
`define WDTC_WMASK 8'h3f
`define CAUSE_RST 8'h00
`define WDTC_RST 8'h16
`define BORC_RST 8'h80
`define CFG_RST 14'h3fff
`endif

// File: mode_decode.v
// decodes a two-bit enable field into an effective enable
`timescale 1ns/10ps
module mode_decode (
  input wire [1:0] field_i,  // enable field from the configuration word
  input wire sw_en_i,        // software enable bit
  input wire sleep_i,        // device in sleep
  output reg en_o            // effective enable
);
  `include "cfg_reset_map.vh"
  always @* begin
    case (field_i)
      `MODE_ON: en_o = 1'b1;
      `MODE_RUN: en_o = ~sleep_i;
      `MODE_SW: en_o = sw_en_i;
      default: en_o = 1'b0;
    endcase
  end
endmodule

// File: cfg_reset_opt.v
// configuration word latch and reset option decoder with a wishbone register port
// Overview of operation
// - program memory is protected when the code-protect bit is 0 and unprotected when it is 1.
// - with low-voltage programming on, the pin-function bit is ignored and the pin stays a reset pin.
// - with low-voltage programming off and the pin-function bit at 1, the pin is the reset input with pull-up on.
// - with it off and the bit at 0, the pin is a digital input, reset is off, and the pull-up follows its port bit.
// - watchdog field 11 is always on, 01 follows the software enable, 00 is off.
// - watchdog field 10 runs the watchdog while executing and stops it in sleep.
// - unimplemented bits of the brown-out, cause, status and watchdog registers read 0.
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
module cfg_reset_opt (
  input wire clk_i,               // 250 MHz clock
  input wire rst_i,               // synchronous reset, active high
  input wire [13:0] cfg_word_i,   // configuration word from nonvolatile memory
  input wire cfg_load_i,          // pulse: latch the configuration word
  input wire lvp_i,               // low-voltage programming enabled
  input wire sleep_i,             // device in sleep
  input wire pin_pullup_ctrl_i,   // port pull-up control bit of the shared pin
  input wire bor_ready_i,         // brown-out circuit ready
  input wire [7:0] cause_set_i,   // hardware set pulses for reset-cause flags
  input wire [4:0] status_i,      // core status flags
  input wire [31:0] adr_i,        // wishbone address
  input wire [31:0] dat_i,        // wishbone write data
  input wire [3:0] sel_i,         // wishbone byte selects
  input wire we_i,                // wishbone write
  input wire cyc_i,               // wishbone cycle
  input wire stb_i,               // wishbone strobe
  output reg [31:0] dat_o,        // wishbone read data
  output reg ack_o,               // wishbone acknowledge
  output reg code_protect_o,      // program memory protected
  output reg ext_reset_en_o,      // shared pin acts as external reset
  output reg pin_pullup_o,        // weak pull-up on the shared pin
  output reg watchdog_en_o,       // watchdog running
  output reg brownout_en_o,       // brown-out reset armed
  output reg powerup_timer_en_o   // power-up timer enabled
);
  `include "cfg_reset_map.vh"

  ////////////////////////////////////////////////////////////////////////
  // configuration latch and decode
  // index 0 of the mode channels is the watchdog, index 1 the brown-out reset
  localparam N_MODE = 2;

  reg [13:0] cfg_q;
  reg [7:0] borc_q;
  reg [7:0] cause_q;
  reg [7:0] wdtc_q;
  wire [2*N_MODE-1:0] mode_field_w;
  wire [N_MODE-1:0] mode_sw_w;
  wire [N_MODE-1:0] mode_en_w;
  wire rst_pin_w;
  // next values of the registered option outputs
  reg code_protect_d;
  reg ext_reset_en_d;
  reg pin_pullup_d;
  reg watchdog_en_d;
  reg brownout_en_d;
  reg powerup_timer_en_d;

  // the erased word is the safe default until loaded: no protection, and the
  // shared pin keeps its reset function so a blank part can still be reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= `CFG_RST;
    end else if (cfg_load_i) begin
      cfg_q <= cfg_word_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable mode decoders
  // both two-bit fields share one encoding, so one decoder serves each channel
  assign mode_field_w = {cfg_q[`CFG_BORE_HI:`CFG_BORE_LO], cfg_q[`CFG_WATCHDOG_ENABLE_FIELD_HI:`CFG_WATCHDOG_ENABLE_FIELD_LO]};
  assign mode_sw_w = {borc_q[`BORC_SWEN_BIT], wdtc_q[`WDTC_SWEN_BIT]};

  genvar ch;
  generate
    for (ch = 0; ch < N_MODE; ch = ch + 1) begin : g_mode
      mode_decode u_mode (
        .field_i(mode_field_w[2*ch+1:2*ch]),
        .sw_en_i(mode_sw_w[ch]),
        .sleep_i(sleep_i),
        .en_o(mode_en_w[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // option outputs
  // low-voltage programming makes the pin-function bit a don't-care
  assign rst_pin_w = lvp_i | cfg_q[`CFG_RPFS_BIT];

  always @* begin
    code_protect_d = ~cfg_q[`CFG_CP_BIT];
    ext_reset_en_d = rst_pin_w;
    // pull-up is forced while the pin is a reset pin, else the port bit owns it
    pin_pullup_d = rst_pin_w | pin_pullup_ctrl_i;
    watchdog_en_d = mode_en_w[0];
    brownout_en_d = mode_en_w[1];
    powerup_timer_en_d = ~cfg_q[`CFG_PUTE_BIT];
  end

  // registered so the reset, watchdog and protection logic never sees a decode
  // glitch; the price is one clock of lag after a load or a register write
  always @(posedge clk_i) begin
    if (rst_i) begin
      code_protect_o <= 1'b0;
      ext_reset_en_o <= 1'b1;
      pin_pullup_o <= 1'b1;
      watchdog_en_o <= 1'b0;
      brownout_en_o <= 1'b0;
      powerup_timer_en_o <= 1'b0;
    end else begin
      code_protect_o <= code_protect_d;
      ext_reset_en_o <= ext_reset_en_d;
      pin_pullup_o <= pin_pullup_d;
      watchdog_en_o <= watchdog_en_d;
      brownout_en_o <= brownout_en_d;
      powerup_timer_en_o <= powerup_timer_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: one word per register, single-cycle answer
  wire req_w;
  wire wr_w;
  wire [29:0] idx_w;
  wire [7:0] borc_rd_w;
  wire [7:0] cause_rd_w;
  wire [7:0] status_rd_w;
  wire [7:0] wdtc_rd_w;
  wire [7:0] opt_rd_w;
  reg [7:0] rd_d;

  // an ack in flight blocks a second take of the same bus cycle
  assign req_w = cyc_i & stb_i & ~ack_o;
  // only byte lane zero carries register bits, so a write without it is dropped
  assign wr_w = req_w & we_i & sel_i[0];
  assign idx_w = adr_i[31:2];

  // unimplemented positions are masked on the way out as well as on the way in,
  // so a gap can never read back as 1 whatever the storage holds
  assign borc_rd_w = {borc_q[7:6], 5'h00, bor_ready_i};
  assign cause_rd_w = cause_q & `CAUSE_WMASK;
  assign status_rd_w = {3'h0, status_i} & `STATUS_RMASK;
  assign wdtc_rd_w = wdtc_q & `WDTC_WMASK;
  assign opt_rd_w = {2'h0, powerup_timer_en_o, brownout_en_o, watchdog_en_o,
                     pin_pullup_o, ext_reset_en_o, code_protect_o};

  // the configuration word is wider than a byte and is answered whole below
  always @* begin
    case (idx_w)
      {26'h0, `ADR_CFG_WORD}: rd_d = cfg_q[7:0];
      {26'h0, `ADR_BOR_CTRL}: rd_d = borc_rd_w;
      {26'h0, `ADR_CAUSE}: rd_d = cause_rd_w;
      {26'h0, `ADR_STATUS}: rd_d = status_rd_w;
      {26'h0, `ADR_WDT_CTRL}: rd_d = wdtc_rd_w;
      {26'h0, `ADR_OPT_STAT}: rd_d = opt_rd_w;
      default: rd_d = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req_w;
      // upper six configuration bits sit in byte lane one
      if (req_w && idx_w == {26'h0, `ADR_CFG_WORD}) begin
        dat_o <= {18'h0, cfg_q};
      end else if (req_w) begin
        dat_o <= {24'h0, rd_d};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers
  localparam [7:0] CAUSE_IMPL = `CAUSE_WMASK;
  wire wr_borc_w;
  wire wr_wdtc_w;
  wire wr_cause_w;
  wire [7:0] cause_d;

  assign wr_borc_w = wr_w & (idx_w == {26'h0, `ADR_BOR_CTRL});
  assign wr_wdtc_w = wr_w & (idx_w == {26'h0, `ADR_WDT_CTRL});
  assign wr_cause_w = wr_w & (idx_w == {26'h0, `ADR_CAUSE});

  // the software brown-out enable resets to 1 so a field of 01 starts armed
  always @(posedge clk_i) begin
    if (rst_i) begin
      borc_q <= `BORC_RST;
    end else if (wr_borc_w) begin
      borc_q <= dat_i[7:0] & `BORC_WMASK;
    end
  end

  // watchdog period select and software enable; bits 7:6 do not exist
  always @(posedge clk_i) begin
    if (rst_i) begin
      wdtc_q <= `WDTC_RST;
    end else if (wr_wdtc_w) begin
      wdtc_q <= dat_i[7:0] & `WDTC_WMASK;
    end
  end

  // one slice per flag; a hardware set wins over a software write in the same
  // cycle, so a reset cause that lands while software rewrites the register is kept
  genvar fb;
  generate
    for (fb = 0; fb < 8; fb = fb + 1) begin : g_cause
      assign cause_d[fb] = CAUSE_IMPL[fb] & (cause_set_i[fb] | (wr_cause_w ? dat_i[fb] : cause_q[fb]));
    end
  endgenerate

  // the gap bit is held at 0 by its slice of cause_d
  always @(posedge clk_i) begin
    if (rst_i) begin
      cause_q <= `CAUSE_RST;
    end else begin
      cause_q <= cause_d;
    end
  end
endmodule

// File: cfg_reset_props.sv
// assertion checker for the reset option decoder
`timescale 1ns/10ps
module cfg_reset_props (
  input logic clk_i, rst_i, cfg_load_i, lvp_i, sleep_i, pin_pullup_ctrl_i, we_i, cyc_i, stb_i, ack_o,
  input logic code_protect_o, ext_reset_en_o, pin_pullup_o, watchdog_en_o, brownout_en_o,
  input logic [13:0] cfg_word_i,
  input logic [31:0] adr_i, dat_o
);
  // shadow of the latched word; outputs lag it and the level inputs by one edge
  reg [13:0] w_q;
  always @(posedge clk_i) w_q <= rst_i ? 14'h3fff : (cfg_load_i ? cfg_word_i : w_q);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_cp_level: assert property (!$past(rst_i) |-> code_protect_o == !$past(w_q[7])) else $error("cp wrong");
  chk_lvp_pin: assert property (!$past(rst_i) && $past(lvp_i) |-> ext_reset_en_o && pin_pullup_o)
    else $error("lvp pin wrong");
  chk_pin_reset: assert property (!$past(rst_i) && !$past(lvp_i) && $past(w_q[6]) |-> ext_reset_en_o && pin_pullup_o)
    else $error("reset pin wrong");
  chk_pin_input: assert property (!$past(rst_i) && !$past(lvp_i) && !$past(w_q[6]) |->
    !ext_reset_en_o && pin_pullup_o == $past(pin_pullup_ctrl_i)) else $error("input pin wrong");
  chk_wdt_fixed: assert property (!$past(rst_i) && $past(w_q[4]) == $past(w_q[3]) |->
    watchdog_en_o == $past(w_q[4])) else $error("wdt mode wrong");
  chk_wdt_sleep: assert property (!$past(rst_i) && $past(w_q[4:3]) == 2'h2 |->
    watchdog_en_o == !$past(sleep_i)) else $error("wdt sleep wrong");
  chk_bor_mode: assert property (!$past(rst_i) && $past(w_q[10:9]) != 2'h1 |->
    brownout_en_o == ($past(w_q[10]) && ($past(w_q[9]) || !$past(sleep_i)))) else $error("bor mode wrong");
  chk_status_zero: assert property (ack_o && !we_i && adr_i == 32'hc |-> dat_o[31:5] == 27'h0)
    else $error("status gap set");
  chk_cause_gap: assert property (ack_o && !we_i && adr_i == 32'h8 |-> dat_o[31:8] == 24'h0 && !dat_o[5])
    else $error("cause gap set");
  chk_ack_once: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("ack shape wrong");
  cover property ($past(w_q[4:3]) == 2'h2 && $past(sleep_i));
  cover property (!$past(lvp_i) && !$past(w_q[6]));
  cover property (ack_o && !we_i);
endmodule
bind cfg_reset_opt cfg_reset_props u_props (.*);

// File: cfg_reset_opt_bench.sv
// self-checking bench for the reset option decoder
`timescale 1ns/10ps
module cfg_reset_opt_bench;
  reg clk_i = 0, rst_i = 1, cfg_load_i = 0, lvp_i = 0, sleep_i = 0, pin_pullup_ctrl_i = 0, bor_ready_i = 0;
  reg we_i = 0, cyc_i = 0, stb_i = 0;
  reg [13:0] cfg_word_i = 14'h0;
  reg [7:0] cause_set_i = 8'h0;
  reg [4:0] status_i = 5'h0;
  reg [31:0] adr_i = 32'h0, dat_i = 32'h0, r, q;
  reg [3:0] sel_i = 4'hf;
  wire [31:0] dat_o;
  wire ack_o, code_protect_o, ext_reset_en_o, pin_pullup_o, watchdog_en_o, brownout_en_o, powerup_timer_en_o;
  wire [31:0] outs = {26'h0, powerup_timer_en_o, brownout_en_o, watchdog_en_o, pin_pullup_o, ext_reset_en_o,
                      code_protect_o};
  logic [31:0] exp_q[$];
  int n_errors = 0, compares = 0, i;
  cfg_reset_opt i_dut (.*);
  initial forever #2 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////
  function automatic logic m(input [1:0] f, input e, s);
    m = f[1] ? (f[0] | ~s) : (f[0] & e);
  endfunction
  function automatic [31:0] opt(input [13:0] w, input l, s, p, sw, sb);
    opt = {26'h0, ~w[5], m(w[10:9], sb, s), m(w[4:3], sw, s), l | w[6] | p, l | w[6], ~w[7]};
  endfunction
  task automatic chk(input [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input [31:0] a, input w, input [31:0] d);
    @(posedge clk_i);
    adr_i <= a; we_i <= w; dat_i <= d; cyc_i <= 1; stb_i <= 1;
    // no fixed latency assumed; the watchdog cuts a missing ack short
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
  endtask
  task automatic rd(input [31:0] a, e);
    exp_q.push_back(e);
    wb(a, 0, 32'h0);
  endtask
  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0) chk(dat_o, exp_q.pop_front());
  initial begin
    #20000;
    n_errors++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h1fc32919));
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    rd(32'h14, opt(14'h3fff, 0, 0, 0, 0, 1));
    rd(32'h10, 32'h16);
    for (i = 0; i < 40; i++) begin
      r = $urandom;
      q = $urandom;
      @(posedge clk_i);
      cfg_word_i <= r[13:0]; cfg_load_i <= 1; lvp_i <= r[14]; sleep_i <= r[15];
      pin_pullup_ctrl_i <= r[16]; bor_ready_i <= r[17]; status_i <= r[22:18];
      @(posedge clk_i);
      cfg_load_i <= 0;
      wb(32'h10, 1, q);
      wb(32'h4, 1, q);
      wb(32'h8, 1, q);
      wb(32'h20, 1, q);
      // a write without byte lane zero must leave the register alone
      sel_i <= 4'he;
      wb(32'h10, 1, ~q);
      sel_i <= 4'hf;
      @(posedge clk_i);
      cause_set_i <= r[31:24];
      @(posedge clk_i);
      cause_set_i <= 8'h00;
      rd(32'h0, {18'h0, r[13:0]});
      rd(32'h14, opt(r[13:0], r[14], r[15], r[16], q[0], q[7]));
      chk(outs, opt(r[13:0], r[14], r[15], r[16], q[0], q[7]));
      rd(32'h10, {26'h0, q[5:0]});
      rd(32'h4, {24'h0, q[7:6], 5'h0, r[17]});
      rd(32'h8, {24'h0, q[7:6] | r[31:30], 1'b0, q[4:0] | r[28:24]});
      rd(32'hc, {27'h0, r[22:18]});
      rd(32'h20, 32'h0);
      $display("test %0d done", i);
    end
    // reset in mid-run: options read 06 while in reset, then decode the erased word; registers return to reset values
    @(posedge clk_i);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    chk(outs, 32'h06);
    rst_i <= 0;
    rd(32'h14, opt(14'h3fff, r[14], r[15], r[16], 0, 1));
    chk(outs, opt(14'h3fff, r[14], r[15], r[16], 0, 1));
    rd(32'h10, 32'h16);
    rd(32'h4, {24'h0, 1'b1, 6'h0, r[17]});
    rd(32'h8, 32'h0);
    $display("reset test done");
    end_of_test;
  end
endmodule
